// >>> dv/loop_alarm_status_words_tb.sv
`timescale 1ns/1ps
`default_nettype none
module loop_alarm_status_words_tb;
   logic        clk, arst_n, analog_indicator_loop, scan_tick, config_done, got;
   logic        event_live, event_raise, host_req, host_write, host_coil, host_ack;
   logic [5:0]  loop_number;
   logic [3:0]  alarm_cond_first, alarm_cond_second, cs, cf;
   logic [2:0]  switch_mode_input, switch_closed;
   logic [15:0] host_addr, host_wdata, host_rdata, cb, e;
   logic [15:0] exp_q[$];
   int          err_total, checks_done;
   loop_alarm_status_words u_loop_alarm_status_words (
      .clk(clk), .arst_n(arst_n), .analog_indicator_loop(analog_indicator_loop),
      .loop_number(loop_number), .scan_tick(scan_tick), .alarm_cond_first(alarm_cond_first),
      .alarm_cond_second(alarm_cond_second), .config_done(config_done),
      .event_live(event_live), .event_raise(event_raise),
      .switch_mode_input(switch_mode_input), .host_req(host_req), .host_write(host_write),
      .host_coil(host_coil), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_ack(host_ack), .host_rdata(host_rdata), .switch_closed(switch_closed));
   supervisory_host u_supervisory_host (
      .clk(clk), .host_ack(host_ack), .host_req(host_req), .host_write(host_write),
      .host_coil(host_coil), .host_addr(host_addr), .host_wdata(host_wdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================
   // Helpers
   function automatic logic [15:0] act(input logic [3:0] c);
      act = {6'h00, c[3], 2'b00, c[2], 2'b00, c[1], 2'b00, c[0]};
   endfunction : act
   task automatic chk(input string what, input logic [15:0] ex, input logic [15:0] sv);
      checks_done++;
      if (ex !== sv) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, ex, sv);
      end
   endtask : chk
   // Writes answer with zero data, so the queue holds zero for them
   task automatic xf(input logic w, input logic c, input logic [15:0] a,
                     input logic [15:0] d, input logic [15:0] ex);
      exp_q.push_back(w ? 16'h0000 : ex);
      u_supervisory_host.xfer(w, c, a, d, got);
      chk("ack", 16'h0001, {15'h0000, got});
   endtask : xf
   task automatic scan();
      @(negedge clk);
      scan_tick = 1'b1;
      @(negedge clk);
      scan_tick = 1'b0;
   endtask : scan
   task automatic wrap_up();
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   always @(negedge clk) begin
      if (host_ack === 1'b1) begin
         if (exp_q.size() == 0) chk("extra_ack", 16'h0000, 16'h0001);
         else chk("rdata", exp_q.pop_front(), host_rdata);
      end
   end
   initial begin
      #(4 * 4000);
      err_total++;
      wrap_up();
   end
   // ==========================================
   // Scenarios
   initial begin
      err_total = 0;
      checks_done = 0;
      arst_n = 1'b0;
      analog_indicator_loop = 1'b0;
      scan_tick = 1'b0;
      config_done = 1'b0;
      event_live = 1'b0;
      event_raise = 1'b0;
      switch_mode_input = 3'b101;
      alarm_cond_first = 4'h0;
      alarm_cond_second = 4'h0;
      void'($urandom(22784));
      loop_number = 6'(1 + $urandom % 40);
      cs = 4'($urandom) | 4'h1;
      cf = 4'($urandom) | 4'h2;
      cb = loop_status_pkg::COIL_BASE + 16'd48 * 16'(loop_number - 6'd1);
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      xf(0, 0, 16'h5, 16'h0, 16'h0000);
      xf(1, 0, 16'h4, 16'hffff, 16'h0);
      xf(0, 0, 16'h4, 16'h0, 16'h0000);
      xf(1, 0, 16'h5, 16'hffff, 16'h0);
      xf(0, 0, 16'h5, 16'h0, 16'h5db6);
      xf(1, 0, 16'h5, 16'h0924, 16'h0);
      alarm_cond_second = cs;
      config_done = 1'b1;
      event_live = 1'b1;
      event_raise = 1'b1;
      scan();
      event_raise = 1'b0;
      e = 16'he924 | act(cs) | (act(cs) << 1);
      xf(0, 0, 16'h5, 16'h0, e);
      for (int b = 0; b < 16; b++) xf(0, 1, cb + 16'd16 + 16'(b), 16'h0, {15'h0, e[b]});
      xf(0, 1, cb + 16'd32, 16'h0, 16'h0000);
      xf(1, 0, 16'h5, 16'h1924, 16'h0);
      scan();
      xf(0, 0, 16'h5, 16'h0, 16'hb924);
      analog_indicator_loop = 1'b1;
      alarm_cond_first = cf;
      xf(1, 0, 16'h4, 16'h1924, 16'h0);
      scan();
      xf(0, 0, 16'h4, 16'h0, 16'h1924);
      xf(1, 1, cb + 16'd1, 16'h0001, 16'h0);
      xf(0, 1, cb + 16'd1, 16'h0, 16'h0001);
      xf(1, 0, 16'h4, 16'he924, 16'h0);
      scan();
      chk("switch", 16'h0007, {13'h0, switch_closed});
      xf(0, 0, 16'h4, 16'h0, 16'he924 | act(cf) | (act(cf) << 1));
      scan();
      chk("switch", 16'h0005, {13'h0, switch_closed});
      xf(1, 0, 16'h4, 16'he924, 16'h0);
      scan();
      chk("switch", 16'h0002, {13'h0, switch_closed});
      scan();
      chk("switch", 16'h0000, {13'h0, switch_closed});
      xf(0, 0, 16'h4, 16'h0, 16'h0924 | act(cf));
      wrap_up();
   end
endmodule : loop_alarm_status_words_tb
`default_nettype wire

// >>> dv/supervisory_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host: one strobe a transfer, address and data lines scrambled once released
module supervisory_host (
   input  wire logic        clk,
   input  wire logic        host_ack,
   output var  logic        host_req,
   output var  logic        host_write,
   output var  logic        host_coil,
   output var  logic [15:0] host_addr,
   output var  logic [15:0] host_wdata
);
   initial begin
      host_req   = 1'b0;
      host_write = 1'b0;
      host_coil  = 1'b0;
      host_addr  = 16'h0000;
      host_wdata = 16'h0000;
   end
   // Pending-ack and event bits are written either way
   task automatic xfer(input logic w, input logic c, input logic [15:0] a,
                       input logic [15:0] d, output logic got);
      int n;
      got = 1'b0;
      @(negedge clk);
      host_req   = 1'b1;
      host_write = w;
      host_coil  = c;
      host_addr  = a;
      host_wdata = d;
      @(negedge clk);
      host_req   = 1'b0;
      host_addr  = ~a;
      host_wdata = ~d;
      for (n = 0; n < 4 && got !== 1'b1; n++) begin
         if (host_ack === 1'b1) got = 1'b1;
         else @(negedge clk);
      end
   endtask : xfer
endmodule : supervisory_host
`default_nettype wire

// >>> rtl/loop_alarm_status_words.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Second word holds four alarm triplets active/pending/enabled, alarm four ends bit 11.
// - Active flags are read-only, one while the alarm condition holds, the alarm is enabled and not out of service.
// - Pending-ack flags read one while unacknowledged; host may write them.
// - Enabled flags are host read/write; one enables that alarm.
// - Bit 12 is read/write out-of-service flag for the four alarms of the second word.
// - Bit 13 of second word is read-only, one once loop configured.
// - Bit 14 flags unacknowledged loop event; device sets, host may write.
// - Bit 15 is read-only, one while a loop event is active.
// - Sequencer alarm word answers at channel offset n+5.
// - Analog first word at n+4 holds inputs one and two alarm triplets.
// - Analog second word at n+5 holds inputs three and four triplets.
// - Each bit is also a coil: base plus 48 per loop, consecutive.
// - Analog first word bits 13..15 show the three pushbutton switch states.
// - Writing one to a pushbutton bit acts as press and release.
// - Sustained switch: a written press toggles and holds the position.
// - Momentary switch: a written press closes it for exactly one scan.
// - Analog first word bit 12 is out-of-service for inputs one and two.
// - Sequencer word at n+4 lies outside this block and reads zero.
module loop_alarm_status_words (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        analog_indicator_loop,
   input  wire logic [5:0]  loop_number,
   input  wire logic        scan_tick,
   input  wire logic [3:0]  alarm_cond_first,
   input  wire logic [3:0]  alarm_cond_second,
   input  wire logic        config_done,
   input  wire logic        event_live,
   input  wire logic        event_raise,
   input  wire logic [2:0]  switch_mode_input,
   input  wire logic        host_req,
   input  wire logic        host_write,
   input  wire logic        host_coil,
   input  wire logic [15:0] host_addr,
   input  wire logic [15:0] host_wdata,
   output logic             host_ack,
   output logic [15:0]      host_rdata,
   output logic [2:0]       switch_closed
);
   // ==========================================
   // State
   typedef struct packed {
      logic [15:0] first;
      logic [15:0] second;
      logic [2:0]  closed;
      logic [2:0]  press;
      logic [15:0] rdata;
      logic        ack;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [15:0] loop_base;
   logic [15:0] coil_rel;
   logic        coil_hit;
   logic        sel_first;
   logic        sel_second;
   logic [15:0] wr_first;
   logic [15:0] wr_second;
   logic [15:0] view_first;

   // ==========================================
   // Address decode
   always_comb begin
      loop_base = loop_status_pkg::COIL_BASE
                + 16'(loop_status_pkg::COIL_LOOP_STRIDE * 16'(loop_number - 6'h01));
      coil_rel  = host_addr - loop_base;
      coil_hit  = coil_rel < loop_status_pkg::COIL_MAPPED;
      if (host_coil) begin
         sel_first  = coil_hit && coil_rel < loop_status_pkg::COIL_PER_WORD;
         sel_second = coil_hit && coil_rel >= loop_status_pkg::COIL_PER_WORD;
      end else begin
         sel_first  = host_addr == 16'(loop_status_pkg::WORD_FIRST_OFS);
         sel_second = host_addr == 16'(loop_status_pkg::WORD_SECOND_OFS);
      end
      // Sequencer n+4 word belongs to another block
      sel_first = sel_first && analog_indicator_loop;
      view_first = state_reg.first;
      view_first[15:13] = state_reg.closed;
   end

   // ==========================================
   // Write data, merged per bit for coil access
   always_comb begin
      wr_first  = state_reg.first;
      wr_second = state_reg.second;
      if (host_coil) begin
         wr_first[coil_rel[3:0]]  = host_wdata[0];
         wr_second[coil_rel[3:0]] = host_wdata[0];
      end else begin
         wr_first  = host_wdata;
         wr_second = host_wdata;
      end
   end

   // ==========================================
   // Next state
   always_comb begin
      logic [15:0] wmask;
      logic        act_new;
      logic [2:0]  pressed;
      state_next     = state_reg;
      wmask          = 16'h0000;
      act_new        = 1'b0;
      pressed        = 3'b000;
      state_next.ack = host_req;
      state_next.rdata = 16'h0000;
      if (host_req && !host_write) begin
         if (sel_first) begin
            state_next.rdata = host_coil ? {15'h0000, view_first[coil_rel[3:0]]} : view_first;
         end else if (sel_second) begin
            state_next.rdata = host_coil ? {15'h0000, state_reg.second[coil_rel[3:0]]}
                                         : state_reg.second;
         end
      end
      if (host_req && host_write && sel_first) begin
         wmask = loop_status_pkg::WMASK_FIRST;
         state_next.first = (state_reg.first & ~wmask) | (wr_first & wmask);
         for (int b = 0; b < loop_status_pkg::BUTTONS; b++) begin
            pressed[b] = wr_first[loop_status_pkg::BIT_BUTTON_FIRST + b]
                      && (!host_coil
                      || coil_rel[3:0] == 4'(loop_status_pkg::BIT_BUTTON_FIRST + b));
         end
      end
      if (host_req && host_write && sel_second) begin
         wmask = loop_status_pkg::WMASK_SECOND;
         state_next.second = (state_reg.second & ~wmask) | (wr_second & wmask);
      end
      // Press waits for the scan so the button sees a whole scan
      state_next.press = state_reg.press | pressed;
      if (scan_tick) begin
         for (int i = 0; i < loop_status_pkg::ALARMS_PER_WORD; i++) begin
            act_new = alarm_cond_second[i]
                   && state_next.second[i*3 + loop_status_pkg::FLD_ENABLED]
                   && !state_next.second[loop_status_pkg::BIT_OUT_OF_SVC];
            if (act_new && !state_reg.second[i*3 + loop_status_pkg::FLD_ACTIVE]) begin
               // Set beats a host clear in the same cycle
               state_next.second[i*3 + loop_status_pkg::FLD_PENDING_ACK] = 1'b1;
            end
            state_next.second[i*3 + loop_status_pkg::FLD_ACTIVE] = act_new;
            act_new = alarm_cond_first[i] && analog_indicator_loop
                   && state_next.first[i*3 + loop_status_pkg::FLD_ENABLED]
                   && !state_next.first[loop_status_pkg::BIT_OUT_OF_SVC];
            if (act_new && !state_reg.first[i*3 + loop_status_pkg::FLD_ACTIVE]) begin
               state_next.first[i*3 + loop_status_pkg::FLD_PENDING_ACK] = 1'b1;
            end
            state_next.first[i*3 + loop_status_pkg::FLD_ACTIVE] = act_new;
         end
         state_next.second[loop_status_pkg::BIT_CONFIG_CHG] = config_done;
         state_next.second[loop_status_pkg::BIT_EVENT_LIVE] = event_live;
         if (event_raise) begin
            state_next.second[loop_status_pkg::BIT_EVENT_PEND] = 1'b1;
         end
         for (int b = 0; b < loop_status_pkg::BUTTONS; b++) begin
            if (state_reg.press[b]) begin
               if (switch_mode_input[b]) begin
                  state_next.closed[b] = !state_reg.closed[b];
               end else begin
                  state_next.closed[b] = 1'b1;
               end
            end else if (!switch_mode_input[b]) begin
               state_next.closed[b] = 1'b0;
            end
         end
         state_next.press = pressed;
      end
      state_next.first[15:13] = 3'b000;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign host_ack      = state_reg.ack;
   assign host_rdata    = state_reg.rdata;
   assign switch_closed = state_reg.closed;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_ACK_NEXT: assert property (host_req |=> host_ack)
      else $error("request not answered next cycle");
   AST_ACTIVE_RO: assert property (!scan_tick |=> ($past(state_reg.second[0])
      == state_reg.second[0]) && ($past(state_reg.second[9]) == state_reg.second[9]))
      else $error("active flag changed off scan");
   AST_PEND_RISE: assert property (scan_tick && alarm_cond_second[0]
      && state_reg.second[2] && !state_reg.second[12] && !state_reg.second[0]
      && !(host_req && host_write) |=> state_reg.second[1] && state_reg.second[0])
      else $error("pending ack not raised");
   AST_CONFIG: assert property (scan_tick |=> state_reg.second[13] == $past(config_done))
      else $error("config flag not sampled");
   AST_LIVE: assert property (scan_tick |=> state_reg.second[15] == $past(event_live))
      else $error("event live not sampled");
   AST_EVENT_SET: assert property (scan_tick && event_raise |=> state_reg.second[14])
      else $error("event pending not set");
   AST_OOS_WRITE: assert property (host_req && host_write && !host_coil
      && host_addr == 16'h0005 |=> state_reg.second[12] == $past(host_wdata[12]))
      else $error("out of service write lost");
   AST_MOMENTARY: assert property (scan_tick && state_reg.closed[0]
      && !switch_mode_input[0] && !state_reg.press[0] |=> !switch_closed[0])
      else $error("momentary switch held past one scan");
   AST_SUSTAIN: assert property (scan_tick && state_reg.press[0] && switch_mode_input[0]
      |=> switch_closed[0] != $past(switch_closed[0]))
      else $error("sustained switch did not toggle");
   AST_UNMAPPED: assert property (host_req && !host_write && !host_coil
      && host_addr != 16'h0004 && host_addr != 16'h0005 |=> host_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // ==========================================
   // Host access checks
   AST_ACK_IDLE: assert property (
      !host_req |=> !host_ack)
      else $error("acknowledge without request");
   AST_RDATA_IDLE: assert property (
      !(host_req && !host_write) |=> host_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   AST_READ_SECOND: assert property (
      host_req && !host_write && !host_coil && host_addr == 16'h0005
      |=> host_rdata == $past(state_reg.second))
      else $error("second word read wrong");
   AST_READ_FIRST: assert property (
      host_req && !host_write && !host_coil && host_addr == 16'h0004 && analog_indicator_loop
      |=> host_rdata == {$past(state_reg.closed), $past(state_reg.first[12:0])})
      else $error("first word read wrong");
   AST_SEQ_FIRST_ZERO: assert property (
      host_req && !host_write && !host_coil && host_addr == 16'h0004 && !analog_indicator_loop
      |=> host_rdata == 16'h0000)
      else $error("sequencer first word not zero");
   AST_SEQ_FIRST_HOLD: assert property (
      !analog_indicator_loop && !scan_tick |=> $stable(state_reg.first))
      else $error("first word changed in sequencer mode");
   AST_FIRST_TOP_CLEAR: assert property (
      state_reg.first[15:13] == 3'b000)
      else $error("button bits stored in word");
   AST_RO_WRITE: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0005 && !scan_tick
      |=> $stable(state_reg.second[0]) && $stable(state_reg.second[13])
      && $stable(state_reg.second[15]))
      else $error("read-only bit written");
   AST_ENABLE_WRITE: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0005
      |=> state_reg.second[2] == $past(host_wdata[2]))
      else $error("enable write lost");
   AST_EVENT_WRITE: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0005 && !scan_tick
      |=> state_reg.second[14] == $past(host_wdata[14]))
      else $error("event pending write lost");
   AST_FIRST_EN_WRITE: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0004 && analog_indicator_loop
      |=> state_reg.first[5] == $past(host_wdata[5]))
      else $error("first word enable write lost");
   AST_FIRST_OOS_WRITE: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0004 && analog_indicator_loop
      |=> state_reg.first[12] == $past(host_wdata[12]))
      else $error("first word out of service write lost");

   // ==========================================
   // Coil access checks
   AST_COIL_WRITE: assert property (
      host_req && host_write && host_coil && coil_rel == 16'h0015
      |=> state_reg.second[5] == $past(host_wdata[0]))
      else $error("coil write lost");
   AST_COIL_READ: assert property (
      host_req && !host_write && host_coil && coil_rel == 16'h001d
      |=> host_rdata == {15'h0000, $past(state_reg.second[13])})
      else $error("coil read wrong");
   AST_COIL_SPARE: assert property (
      host_req && !host_write && host_coil && coil_rel >= 16'h0020
      |=> host_rdata == 16'h0000)
      else $error("spare coil not zero");
   AST_COIL_NARROW: assert property (
      host_req && host_write && host_coil && coil_rel == 16'h0011 && !scan_tick
      |=> $stable(state_reg.second[2]))
      else $error("coil write touched a neighbour");

   // ==========================================
   // Scan boundary checks
   AST_ACTIVE_RO_FIRST: assert property (
      !scan_tick |=> $stable(state_reg.first[0]) && $stable(state_reg.first[3]))
      else $error("first word active flag changed off scan");
   AST_ACTIVE_RO_MID: assert property (
      !scan_tick |=> $stable(state_reg.second[3]) && $stable(state_reg.second[6]))
      else $error("second word active flag changed off scan");
   AST_CONFIG_HOLD: assert property (
      !scan_tick |=> $stable(state_reg.second[13]))
      else $error("config flag changed off scan");
   AST_LIVE_HOLD: assert property (
      !scan_tick |=> $stable(state_reg.second[15]))
      else $error("event live changed off scan");
   AST_PEND_HOLD: assert property (
      !scan_tick && !(host_req && host_write) |=> $stable(state_reg.second[1]))
      else $error("pending ack changed without cause");
   AST_EVENT_HOLD: assert property (
      !scan_tick && !(host_req && host_write) |=> $stable(state_reg.second[14]))
      else $error("event pending changed without cause");
   AST_ACTIVE_GATE: assert property (
      scan_tick && !(host_req && host_write)
      |=> state_reg.second[0] == ($past(alarm_cond_second[0]) && $past(state_reg.second[2])
      && !$past(state_reg.second[12])))
      else $error("alarm one active wrong");
   AST_ALARM_FOUR: assert property (
      scan_tick && !(host_req && host_write)
      |=> state_reg.second[9] == ($past(alarm_cond_second[3]) && $past(state_reg.second[11])
      && !$past(state_reg.second[12])))
      else $error("alarm four active wrong");
   AST_DISABLED_QUIET: assert property (
      scan_tick && !state_reg.second[5] && !(host_req && host_write)
      |=> !state_reg.second[3])
      else $error("disabled alarm went active");
   AST_OOS_BLOCKS: assert property (
      scan_tick && state_reg.second[12] && !(host_req && host_write)
      |=> !state_reg.second[0] && !state_reg.second[3] && !state_reg.second[6]
      && !state_reg.second[9])
      else $error("alarm active while out of service");
   AST_OOS_FIRST: assert property (
      scan_tick && state_reg.first[12] && !(host_req && host_write)
      |=> !state_reg.first[0] && !state_reg.first[3] && !state_reg.first[6]
      && !state_reg.first[9])
      else $error("input alarm active while out of service");
   AST_PEND_FIRST: assert property (
      scan_tick && analog_indicator_loop && alarm_cond_first[0] && state_reg.first[2]
      && !state_reg.first[12] && !state_reg.first[0] && !(host_req && host_write)
      |=> state_reg.first[1] && state_reg.first[0])
      else $error("input alarm pending ack not raised");
   AST_PEND_SET_WINS: assert property (
      scan_tick && host_req && host_write && !host_coil && host_addr == 16'h0005
      && alarm_cond_second[0] && host_wdata[2] && !host_wdata[12] && !state_reg.second[0]
      |=> state_reg.second[1])
      else $error("host clear beat a new alarm");

   // ==========================================
   // Pushbutton checks
   AST_PRESS_LATCH: assert property (
      host_req && host_write && !host_coil && host_addr == 16'h0004 && analog_indicator_loop
      && host_wdata[13] |=> state_reg.press[0])
      else $error("button press not latched");
   AST_PRESS_HOLD: assert property (
      !scan_tick && !(host_req && host_write) |=> $stable(state_reg.press))
      else $error("button press changed without cause");
   AST_PRESS_DONE: assert property (
      scan_tick && !(host_req && host_write) |=> state_reg.press == 3'b000)
      else $error("button press not consumed at scan");
   AST_SWITCH_IDLE: assert property (
      !scan_tick |=> $stable(switch_closed))
      else $error("switch moved off scan");
   AST_MOMENTARY_CLOSE: assert property (
      scan_tick && state_reg.press[1] && !switch_mode_input[1] |=> switch_closed[1])
      else $error("momentary switch did not close");
   AST_SUSTAIN_HOLD: assert property (
      scan_tick && !state_reg.press[2] && switch_mode_input[2] |=> $stable(switch_closed[2]))
      else $error("sustained switch moved without press");
endmodule : loop_alarm_status_words
`default_nettype wire

// >>> rtl/loop_status_pkg.sv
`default_nettype none
package loop_status_pkg;
   // ==========================================
   // Word offsets from the loop's base channel n
   localparam logic [3:0]  WORD_FIRST_OFS    = 4'h4;
   localparam logic [3:0]  WORD_SECOND_OFS   = 4'h5;
   // ==========================================
   // Coil numbering: base + stride * (loop - 1)
   localparam logic [15:0] COIL_BASE         = 16'h0128;
   localparam logic [15:0] COIL_LOOP_STRIDE  = 16'h0030;
   localparam logic [15:0] COIL_PER_WORD     = 16'h0010;
   localparam logic [15:0] COIL_MAPPED       = 16'h0020;
   // ==========================================
   // Bit layout: triplets and bit 12 shared by both words, bits 13..15 differ per word
   localparam int          ALARMS_PER_WORD   = 4;
   localparam int          TRIPLET           = 3;
   localparam int          FLD_ACTIVE        = 0;
   localparam int          FLD_PENDING_ACK   = 1;
   localparam int          FLD_ENABLED       = 2;
   localparam int          BIT_OUT_OF_SVC    = 12;
   localparam int          BIT_CONFIG_CHG    = 13;
   localparam int          BIT_EVENT_PEND    = 14;
   localparam int          BIT_EVENT_LIVE    = 15;
   localparam int          BIT_BUTTON_FIRST  = 13;
   localparam int          BUTTONS           = 3;
   // ==========================================
   // Host write masks and reset values
   localparam logic [15:0] WMASK_SECOND      = 16'h5db6;
   localparam logic [15:0] WMASK_FIRST       = 16'h1db6;
   localparam logic [15:0] WORD_RESET        = 16'h0000;
endpackage : loop_status_pkg
`default_nettype wire
